//--- logic/ext_mem_pkg.sv
// Package with register map, field layout, modes and timing for the external data memory unit.
// What this block does
// (R1) Eight-bit pointer accesses take the high address byte from the page register.
// (R2) Page value N maps eight-bit accesses onto N*256 through N*256+255.
// (R3) Pin sharing select 0 shares low address and data pins; 1 separates them.
// (R4) Map mode 00 sends every access on-chip, addresses alias into on-chip space.
// (R5) Mode 01 splits at boundary; eight-bit off-chip leaves upper address undriven.
// (R6) Software loads an off-chip page before eight-bit off-chip access in mode 01.
// (R7) Mode 10 splits at boundary; eight-bit off-chip drives page as upper byte.
// (R8) Mode 11 sends every access off-chip; on-chip RAM invisible.
// (R9) Latch strobe high and low periods each last width field plus one cycles.
// (R10) Latch strobe width matters only in multiplexed operation.
// (R11) Upper three configuration bits read zero and ignore writes.
// (R12) Multiplexed: low address while strobe high, then data during read or write strobe.
// (R13) Multiplexed: data and low address share lines, latched externally by the strobe.
// (R14) Sixteen-bit pointer decides on/off-chip and drives all sixteen address lines.
// (R15) External-only eight-bit access ignores page, drives only the low byte.
// (R16) Read and write strobes are active low and idle high.
package ext_mem_pkg;

  localparam logic [7:0] PAGE_OFFSET      = 8'haa;
  localparam logic [7:0] CONFIG_OFFSET    = 8'hb2;
  localparam logic [7:0] PAGE_RESET       = 8'h00;
  localparam logic [7:0] CONFIG_RESET     = 8'h03;
  localparam logic [7:0] CONFIG_WRITABLE  = 8'h1f;
  localparam int         PIN_SHARE_BIT    = 4;
  localparam int         MAP_MODE_LSB     = 2;
  localparam int         LATCH_WIDTH_LSB  = 0;
  localparam logic [15:0] ONCHIP_SIZE     = 16'h1000;
  localparam logic [15:0] ONCHIP_MASK     = 16'h0fff;
  localparam logic [1:0] STROBE_CYCLES    = 2'h0;

  typedef enum logic [1:0] {
    MAP_INTERNAL   = 2'b00,
    MAP_SPLIT_NOBANK = 2'b01,
    MAP_SPLIT_BANK = 2'b10,
    MAP_EXTERNAL   = 2'b11
  } map_mode_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       wide_ptr;
    logic [15:0] pointer;
    logic [7:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic       pin_sharing_select;
    map_mode_e  memory_map_mode;
    logic [1:0] latch_strobe_width;
  } mem_cfg_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ALE_H = 5'b00010,
    ST_ALE_L = 5'b00100,
    ST_STRB  = 5'b01000,
    ST_DONE  = 5'b10000
  } bus_state_e;

endpackage

//--- logic/ext_bus_sequencer.sv
// Off-chip bus sequencer: latch strobe phases, read and write strobes, pin drive.
`timescale 1ns/1ps
module ext_bus_sequencer (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Request from the steering logic.
  input  wire logic                    start_i,
  input  wire logic                    write_i,
  input  wire logic                    drive_high_i,
  input  wire logic [15:0]             addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire ext_mem_pkg::mem_cfg_s   cfg_i,
  output logic                         busy_o,
  output logic                         done_o,
  output logic [7:0]                   rdata_o,
  // Pins.
  input  wire logic [7:0]              data_pin_i,
  output logic [7:0]                   data_o,
  output logic                         data_oe_o,
  output logic [7:0]                   addr_lo_o,
  output logic                         addr_lo_oe_o,
  output logic [7:0]                   addr_hi_o,
  output logic                         addr_hi_oe_o,
  output logic                         latch_strobe_o,
  output logic                         rd_n_o,
  output logic                         wr_n_o
);
  import ext_mem_pkg::*;

  bus_state_e  state_q;
  logic [1:0]  cnt_q;
  logic        write_q;
  logic        hi_q;
  logic        mux_q;
  logic        fin_q;
  logic [7:0]  data_sync1_q;
  logic [7:0]  data_sync2_q;

  // The cycle spent waiting for the synchronised read data still counts as busy.
  assign busy_o = (state_q != ST_IDLE) || fin_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_sync1_q <= 8'h00;
      data_sync2_q <= 8'h00;
    end else begin
      data_sync1_q <= data_pin_i;
      data_sync2_q <= data_sync1_q;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'h0;
      write_q <= 1'b0;
      hi_q    <= 1'b0;
      mux_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            write_q <= write_i;
            hi_q    <= drive_high_i;
            mux_q   <= ~cfg_i.pin_sharing_select; // R3
            cnt_q   <= cfg_i.latch_strobe_width; // R9
            state_q <= cfg_i.pin_sharing_select ? ST_STRB : ST_ALE_H; // R10
            if (cfg_i.pin_sharing_select) begin
              cnt_q <= STROBE_CYCLES;
            end
          end
        end
        ST_ALE_H: begin
          if (cnt_q == 2'h0) begin
            cnt_q   <= cfg_i.latch_strobe_width; // R9
            state_q <= ST_ALE_L;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        ST_ALE_L: begin
          if (cnt_q == 2'h0) begin
            cnt_q   <= STROBE_CYCLES;
            state_q <= ST_STRB;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        ST_STRB: begin
          if (cnt_q == 2'h0) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Pin data taken at the end of the strobe needs two synchroniser edges, so completion
  // waits one cycle after the done state before the second flip-flop is read.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fin_q   <= 1'b0;
      rdata_o <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      fin_q  <= (state_q == ST_DONE);
      done_o <= fin_q;
      if (fin_q && !write_q) begin
        rdata_o <= data_sync2_q;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_lo_o      <= 8'h00;
      addr_hi_o      <= 8'h00;
      addr_lo_oe_o   <= 1'b0;
      addr_hi_oe_o   <= 1'b0;
      data_o         <= 8'h00;
      data_oe_o      <= 1'b0;
      latch_strobe_o <= 1'b0;
      rd_n_o         <= 1'b1;
      wr_n_o         <= 1'b1;
    end else begin
      if (state_q == ST_IDLE && start_i) begin
        addr_lo_o <= addr_i[7:0];
        addr_hi_o <= addr_i[15:8];
        data_o    <= cfg_i.pin_sharing_select ? wdata_i : addr_i[7:0]; // R12 R13
      end else if (state_q == ST_ALE_L && cnt_q == 2'h0) begin
        data_o <= wdata_i; // R12
      end
      latch_strobe_o <= (state_q == ST_IDLE && start_i && !cfg_i.pin_sharing_select)
                        || (state_q == ST_ALE_H && cnt_q != 2'h0); // R9 R12
      addr_lo_oe_o <= (state_q == ST_IDLE) ? (start_i && cfg_i.pin_sharing_select)
                      : (busy_o && state_q != ST_DONE && !mux_q);
      addr_hi_oe_o <= (state_q == ST_IDLE) ? (start_i && drive_high_i)
                      : (hi_q && state_q != ST_DONE); // R5 R15
      data_oe_o <= (state_q == ST_IDLE) ? (start_i && (!cfg_i.pin_sharing_select || write_i))
                   : (state_q != ST_DONE && (write_q || state_q == ST_ALE_H
                      || (state_q == ST_ALE_L && cnt_q != 2'h0))); // R12
      rd_n_o <= ~(((state_q == ST_ALE_L && cnt_q == 2'h0) || (state_q == ST_IDLE && start_i
                  && cfg_i.pin_sharing_select)) && !(state_q == ST_IDLE ? write_i : write_q)); // R16
      wr_n_o <= ~(((state_q == ST_ALE_L && cnt_q == 2'h0) || (state_q == ST_IDLE && start_i
                  && cfg_i.pin_sharing_select)) && (state_q == ST_IDLE ? write_i : write_q)); // R16
    end
  end

endmodule

//--- logic/ext_mem_iface_config.sv
// Top of the external data memory unit: registers, address steering and bus sequencer.
`timescale 1ns/1ps
module ext_mem_iface_config (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Special function register port from the core.
  input  wire logic [7:0]              sfr_addr_i,
  input  wire logic                    sfr_wr_i,
  input  wire logic [7:0]              sfr_wdata_i,
  output logic [7:0]                   sfr_rdata_o,
  // External data move request from the core.
  input  wire ext_mem_pkg::mem_req_s   req_i,
  output logic                         req_done_o,
  output logic [7:0]                   req_rdata_o,
  // On-chip data RAM port.
  output logic                         ram_en_o,
  output logic                         ram_we_o,
  output logic [11:0]                  ram_addr_o,
  output logic [7:0]                   ram_wdata_o,
  input  wire logic [7:0]              ram_rdata_i,
  // Off-chip pins.
  input  wire logic [7:0]              data_pin_i,
  output logic [7:0]                   data_o,
  output logic                         data_oe_o,
  output logic [7:0]                   addr_lo_o,
  output logic                         addr_lo_oe_o,
  output logic [7:0]                   addr_hi_o,
  output logic                         addr_hi_oe_o,
  output logic                         latch_strobe_o,
  output logic                         rd_n_o,
  output logic                         wr_n_o
);
  import ext_mem_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  page_high_byte_q;
  logic [7:0]  ext_memory_config_q;
  mem_cfg_s    cfg;
  logic [15:0] eff_addr;
  logic        off_chip;
  logic        drive_high;
  logic        ram_pend_q;
  logic        bus_busy;
  logic        bus_done;
  logic [7:0]  bus_rdata;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_high_byte_q    <= PAGE_RESET;
      ext_memory_config_q <= CONFIG_RESET;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == PAGE_OFFSET) begin
        page_high_byte_q <= sfr_wdata_i;
      end
      if (sfr_addr_i == CONFIG_OFFSET) begin
        ext_memory_config_q <= sfr_wdata_i & CONFIG_WRITABLE; // R11
      end
    end
  end

  always_comb begin
    case (sfr_addr_i)
      PAGE_OFFSET:   sfr_rdata_o = page_high_byte_q;
      CONFIG_OFFSET: sfr_rdata_o = ext_memory_config_q; // R11
      default:       sfr_rdata_o = 8'h00;
    endcase
  end

  assign cfg.pin_sharing_select = ext_memory_config_q[PIN_SHARE_BIT];
  assign cfg.memory_map_mode    = map_mode_e'(ext_memory_config_q[MAP_MODE_LSB +: 2]);
  assign cfg.latch_strobe_width = ext_memory_config_q[LATCH_WIDTH_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Effective address: the page register supplies the high byte of narrow pointers.
  assign eff_addr = req_i.wide_ptr ? req_i.pointer
                    : {page_high_byte_q, req_i.pointer[7:0]}; // R1 R2 R14

  always_comb begin
    case (cfg.memory_map_mode)
      MAP_INTERNAL:     off_chip = 1'b0; // R4
      MAP_SPLIT_NOBANK: off_chip = (eff_addr >= ONCHIP_SIZE); // R5 R6
      MAP_SPLIT_BANK:   off_chip = (eff_addr >= ONCHIP_SIZE); // R7
      MAP_EXTERNAL:     off_chip = 1'b1; // R8
      default:          off_chip = 1'b0;
    endcase
  end

  always_comb begin
    case (cfg.memory_map_mode)
      MAP_SPLIT_BANK: drive_high = 1'b1; // R7
      default:        drive_high = req_i.wide_ptr; // R5 R14 R15
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // On-chip path answers two cycles after the request.
  assign ram_en_o    = req_i.valid && !off_chip && !bus_busy && !ram_pend_q;
  assign ram_we_o    = req_i.write;
  assign ram_addr_o  = eff_addr[11:0] & ONCHIP_MASK[11:0]; // R4
  assign ram_wdata_o = req_i.wdata;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ram_pend_q <= 1'b0;
    end else begin
      ram_pend_q <= ram_en_o;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_rdata_o <= 8'h00;
      req_done_o  <= 1'b0;
    end else begin
      req_done_o <= ram_pend_q || bus_done;
      if (ram_pend_q) begin
        req_rdata_o <= ram_rdata_i;
      end else if (bus_done) begin
        req_rdata_o <= bus_rdata;
      end
    end
  end

  ext_bus_sequencer u_seq (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .start_i        (req_i.valid && off_chip && !bus_busy && !bus_done && !ram_pend_q),
    .write_i        (req_i.write),
    .drive_high_i   (drive_high),
    .addr_i         (eff_addr),
    .wdata_i        (req_i.wdata),
    .cfg_i          (cfg),
    .busy_o         (bus_busy),
    .done_o         (bus_done),
    .rdata_o        (bus_rdata),
    .data_pin_i     (data_pin_i),
    .data_o         (data_o),
    .data_oe_o      (data_oe_o),
    .addr_lo_o      (addr_lo_o),
    .addr_lo_oe_o   (addr_lo_oe_o),
    .addr_hi_o      (addr_hi_o),
    .addr_hi_oe_o   (addr_hi_oe_o),
    .latch_strobe_o (latch_strobe_o),
    .rd_n_o         (rd_n_o),
    .wr_n_o         (wr_n_o)
  );

endmodule

//--- sim/ext_mem_iface_config_checker.sv
// Port-level assertions for the external data memory unit.
`timescale 1ns/1ps
module ext_mem_checker
  import ext_mem_pkg::*;
(
  // Clock and reset.
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  // Register port.
  input wire logic [7:0]            sfr_addr_i,
  input wire logic                  sfr_wr_i,
  input wire logic [7:0]            sfr_wdata_i,
  // Request port.
  input wire ext_mem_pkg::mem_req_s req_i,
  input wire logic                  req_done_o,
  input wire logic                  ram_en_o,
  // Pins.
  input wire logic [7:0]            data_o,
  input wire logic                  data_oe_o,
  input wire logic [7:0]            addr_hi_o,
  input wire logic                  addr_hi_oe_o,
  input wire logic                  latch_strobe_o,
  input wire logic                  rd_n_o,
  input wire logic                  wr_n_o
);
  logic [7:0] cfg_q;
  logic [7:0] pg_q;
  logic [2:0] hi_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of both registers, so mode-dependent rules can be judged.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= CONFIG_RESET;
      pg_q  <= PAGE_RESET;
    end else if (sfr_wr_i && sfr_addr_i == CONFIG_OFFSET) begin
      cfg_q <= sfr_wdata_i;
    end else if (sfr_wr_i && sfr_addr_i == PAGE_OFFSET) begin
      pg_q <= sfr_wdata_i;
    end
  end
  // Counts the cycles of the current latch strobe high period.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_q <= 3'h0;
    end else begin
      hi_q <= latch_strobe_o ? hi_q + 3'h1 : 3'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_strobe_idle: assert property (!req_i.valid |-> rd_n_o && wr_n_o)
    else $error("strobe active without request");
  a_internal_pins: assert property (cfg_q[3:2] == 2'b00 |-> rd_n_o && wr_n_o)
    else $error("off-chip strobe in internal mode");
  a_external_ram: assert property (cfg_q[3:2] == 2'b11 |-> !ram_en_o)
    else $error("on-chip access in external mode");
  a_upper_idle: assert property (req_i.valid && !req_i.wide_ptr && cfg_q[3:2] != 2'b10
    |-> !addr_hi_oe_o) else $error("upper address driven");
  a_page_drive: assert property (req_i.valid && !req_i.wide_ptr && cfg_q[3:2] == 2'b10
    && !(rd_n_o && wr_n_o) |-> addr_hi_oe_o && addr_hi_o == pg_q) else $error("page not on bus");
  a_wide_addr: assert property (req_i.valid && req_i.wide_ptr && !(rd_n_o && wr_n_o)
    |-> addr_hi_oe_o && addr_hi_o == req_i.pointer[15:8]) else $error("wide upper address");
  a_latch_width: assert property (!latch_strobe_o && hi_q != 3'h0
    |-> hi_q == {1'b0, cfg_q[1:0]} + 3'h1) else $error("latch strobe width");
  a_nomux_latch: assert property (cfg_q[4] |-> !latch_strobe_o)
    else $error("latch strobe in non-multiplexed mode");
  a_mux_addr: assert property (latch_strobe_o && req_i.valid
    |-> data_oe_o && data_o == req_i.pointer[7:0]) else $error("low address on shared lines");
  a_write_data: assert property (!wr_n_o |-> data_oe_o && data_o == req_i.wdata)
    else $error("write data on lines");
  a_onchip_done: assert property ($rose(ram_en_o) |-> ##2 req_done_o)
    else $error("on-chip completion late");
  c_nomux: cover property (req_done_o && cfg_q[4]);
  c_wide_latch: cover property (latch_strobe_o && cfg_q[1:0] == 2'b11);
  c_onchip: cover property ($rose(ram_en_o));
endmodule

bind ext_mem_iface_config ext_mem_checker u_checker (.clk_i, .sys_rst_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_wdata_i, .req_i, .req_done_o, .ram_en_o, .data_o, .data_oe_o, .addr_hi_o,
  .addr_hi_oe_o, .latch_strobe_o, .rd_n_o, .wr_n_o);

//--- sim/ext_mem_partner.sv
// Behavioural off-chip byte memory hanging on the unit's pins.
`timescale 1ns/1ps
module ext_mem_partner (
  // Clock.
  input  wire logic       clk_i,
  // Pins driven by the unit.
  input  wire logic [7:0] data_o,
  input  wire logic [7:0] addr_lo_o,
  input  wire logic       addr_lo_oe_o,
  input  wire logic [7:0] addr_hi_o,
  input  wire logic       addr_hi_oe_o,
  input  wire logic       latch_strobe_o,
  input  wire logic       rd_n_o,
  input  wire logic       wr_n_o,
  // Data lines back to the unit.
  output logic      [7:0] data_pin_o
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_q  = 8'h00;
  logic [7:0]  last_q = 8'h00;
  logic [1:0]  hold_q = 2'h0;
  logic [15:0] addr;
  // Undriven upper lines rest at the parked port level of all ones.
  assign addr = {addr_hi_oe_o ? addr_hi_o : 8'hff, addr_lo_oe_o ? addr_lo_o : lat_q};
  // Released lines hold the last byte for two cycles, then show its inverse, so stale data cannot pass later.
  assign data_pin_o = !rd_n_o ? mem[addr] : (hold_q != 2'h0 ? last_q : ~last_q);
  always @(posedge clk_i) begin
    if (latch_strobe_o) begin
      lat_q <= data_o;
    end
    if (!wr_n_o) begin
      mem[addr] <= data_o;
    end
    if (!rd_n_o) begin
      last_q <= mem[addr];
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
endmodule

//--- sim/ext_mem_iface_config_test.sv
// Self-checking testbench of the external data memory unit.
`timescale 1ns/1ps
module ext_mem_iface_config_test;
  import ext_mem_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, sfr_wr_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, ram_rdata_i = 8'h00, data_pin_i;
  mem_req_s req_i = '0;
  logic [7:0] sfr_rdata_o, req_rdata_o, ram_wdata_o, data_o, addr_lo_o, addr_hi_o, q, wv;
  logic req_done_o, ram_en_o, ram_we_o, data_oe_o, addr_lo_oe_o, addr_hi_oe_o;
  logic latch_strobe_o, rd_n_o, wr_n_o, re, we;
  logic [11:0] ram_addr_o, ra;
  int fails = 0, checks = 0, al;
  always #5 clk_i = ~clk_i;
  // The on-chip RAM answers one cycle later with a pattern built from its address.
  always @(posedge clk_i) ram_rdata_i <= ram_addr_o[7:0] ^ 8'h5a;
  ext_mem_iface_config dut (.clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rdata_o, .req_i, .req_done_o, .req_rdata_o, .ram_en_o, .ram_we_o, .ram_addr_o,
    .ram_wdata_o, .ram_rdata_i, .data_pin_i, .data_o, .data_oe_o, .addr_lo_o, .addr_lo_oe_o,
    .addr_hi_o, .addr_hi_oe_o, .latch_strobe_o, .rd_n_o, .wr_n_o);
  ext_mem_partner u_partner (.clk_i, .data_o, .addr_lo_o, .addr_lo_oe_o, .addr_hi_o,
    .addr_hi_oe_o, .latch_strobe_o, .rd_n_o, .wr_n_o, .data_pin_o(data_pin_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    sfr_addr_i = a;
    #1;
    chk({8'h00, sfr_rdata_o}, {8'h00, exp});
  endtask
  task automatic xfer(input logic w, input logic wd, input logic [15:0] p, input logic [7:0] d);
    int n;
    @(negedge clk_i);
    req_i = '{1'b1, w, wd, p, d};
    #1;
    re = ram_en_o;
    ra = ram_addr_o;
    we = ram_we_o;
    wv = ram_wdata_o;
    al = 0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      al += int'(latch_strobe_o === 1'b1);
    end while (req_done_o !== 1'b1 && n < 60);
    if (n >= 60) begin
      fails++;
      tally_and_finish();
    end
    q = req_rdata_o;
    req_i.valid = 1'b0;
  endtask
  // Off-chip write, then read back through a wide pointer.
  task automatic wr_rd(input logic [7:0] cfg, input logic [7:0] pg, input logic wd,
                       input logic [15:0] wp, input logic [15:0] rp, input logic [7:0] d);
    sfr_wr(CONFIG_OFFSET, cfg);
    sfr_wr(PAGE_OFFSET, pg);
    xfer(1'b1, wd, wp, d);
    chk({15'h0, re}, 16'h0000);
    xfer(1'b0, 1'b1, rp, 8'h00);
    chk({8'h00, q}, {8'h00, d});
    chk(al[15:0], cfg[4] ? 16'h0000 : {14'h0, cfg[1:0]} + 16'h0001);
  endtask
  task automatic onchip(input logic [7:0] cfg, input logic [7:0] pg, input logic wd,
                        input logic [15:0] p, input logic [11:0] exp);
    sfr_wr(CONFIG_OFFSET, cfg);
    sfr_wr(PAGE_OFFSET, pg);
    xfer(1'b1, wd, p, exp[7:0] ^ 8'ha5);
    chk({15'h0, re}, 16'h0001);
    chk({15'h0, we}, 16'h0001);
    chk({4'h0, ra}, {4'h0, exp});
    chk({8'h00, wv}, {8'h00, exp[7:0] ^ 8'ha5});
    xfer(1'b0, wd, p, 8'h00);
    chk({15'h0, re}, 16'h0001);
    chk({15'h0, we}, 16'h0000);
    chk({4'h0, ra}, {4'h0, exp});
    chk({8'h00, q}, {8'h00, exp[7:0] ^ 8'h5a});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    sfr_rd(PAGE_OFFSET, PAGE_RESET);
    sfr_rd(CONFIG_OFFSET, CONFIG_RESET);
    sfr_rd(8'hb0, 8'h00);
    sfr_wr(CONFIG_OFFSET, 8'hff);
    sfr_rd(CONFIG_OFFSET, 8'h1f);
    onchip(8'h00, 8'h12, 1'b0, 16'h0034, 12'h234);
    onchip(8'h00, 8'h00, 1'b1, 16'h2345, 12'h345);
    onchip(8'h14, 8'h00, 1'b0, 16'h0008, 12'h008);
    onchip(8'h18, 8'h00, 1'b1, 16'h0fff, 12'hfff);
    wr_rd(8'h1c, 8'h00, 1'b1, 16'h00c0, 16'h00c0, 8'h11);
    for (int w = 0; w < 4; w++) begin
      wr_rd(8'h0c | 8'(w), 8'h00, 1'b1, 16'h00c1 + 16'(w), 16'h00c1 + 16'(w), 8'h22 + 8'(w));
    end
    wr_rd(8'h14, 8'h20, 1'b0, 16'h0005, 16'hff05, 8'h3c);
    wr_rd(8'h18, 8'h21, 1'b0, 16'h0006, 16'h2106, 8'h4d);
    wr_rd(8'h08, 8'hff, 1'b0, 16'h00ff, 16'hffff, 8'h5e);
    wr_rd(8'h1c, 8'h22, 1'b0, 16'h0007, 16'hff07, 8'h6f);
    tally_and_finish();
  end
endmodule
